// *** rtl/bhl_delay_pipe.sv ***
`timescale 1ns/1ps
// Delays the load control word so the destination write lands in E5.
module bhl_delay_pipe
    import bhl_pkg::*;
#(
    parameter int DEPTH = LOAD_DELAY_SLOTS
)
(
    input  wire logic i_clk,
    input  wire logic i_resetn,
    bhl_wb_if.dly     in_if,
    output logic      o_valid,
    output logic      o_file_b,
    output logic [4:0] o_dst,
    output logic [2:0] o_op,
    output logic [1:0] o_lane
);

    // Elaboration check: the pipe needs one stage at least.
    if (DEPTH < 1)
    begin
        $error("DEPTH must be at least one");
    end

    // Valid, file, index, type and lane: 1 + 1 + 5 + 3 + 2 bits.
    typedef logic [11:0] bhl_word_t;

    bhl_word_t pipe_reg [DEPTH];
    bhl_word_t pipe_next [DEPTH];

    // -------------------------------------------------------------------------
    // Shift stage contents one step per clock.
    // -------------------------------------------------------------------------
    always_comb
    begin
        pipe_next[0] = {in_if.valid, in_if.file_b, in_if.dst, in_if.op, in_if.lane};
        for (int i = 1; i < DEPTH; i++)
        begin
            pipe_next[i] = pipe_reg[i-1];
        end
    end

    // Registers the stages; reset clears the whole word of every stage.
    always_ff @(posedge i_clk)
    begin
        for (int i = 0; i < DEPTH; i++)
        begin
            if (!i_resetn)
            begin
                pipe_reg[i] <= '0;
            end
            else
            begin
                pipe_reg[i] <= pipe_next[i];
            end
        end
    end

    assign o_valid  = pipe_reg[DEPTH-1][11];
    assign o_file_b = pipe_reg[DEPTH-1][10];
    assign o_dst    = pipe_reg[DEPTH-1][9:5];
    assign o_op     = pipe_reg[DEPTH-1][4:2];
    assign o_lane   = pipe_reg[DEPTH-1][1:0];

endmodule

// *** rtl/bhl_load_unit.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Side bit picks data unit and file
// - Offset from register or 5-bit immediate
// - Byte offset is not shifted
// - Halfword offset shifted left by one
// - Pre and offset modes address computed value
// - Post modes address original base, write back
// - Circular arithmetic for enabled A4-A7/B4-B7
// - Type 010 signed byte, 001 unsigned
// - Type 100 signed half, 000 unsigned
// - Byte fills low 8, extend upper 24
// - Halfword fills low 16, extend upper
// - Destination bit selects file A or B
// - Long form base B14/B15, second unit
// - Long form adds only, linear arithmetic
// - Base update E1, data write E5
// - Word offset shifted by two, full width
module bhl_load_unit
    import bhl_pkg::*;
#(
    parameter int DW = 32
)
(
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_issue,
    input  wire logic [31:0] i_instr,
    input  wire logic        i_pred_true,
    input  wire logic [31:0] i_a_rd_base,
    input  wire logic [31:0] i_a_rd_ofs,
    input  wire logic [31:0] i_b_rd_base,
    input  wire logic [31:0] i_b_rd_ofs,
    input  wire logic [15:0] i_circ_mode,
    input  wire logic [4:0]  i_circ_blk_a,
    input  wire logic [4:0]  i_circ_blk_b,
    input  wire logic [31:0] i_mem_rdata,
    output logic [4:0]       o_a_rd_base_idx,
    output logic [4:0]       o_a_rd_ofs_idx,
    output logic [4:0]       o_b_rd_base_idx,
    output logic [4:0]       o_b_rd_ofs_idx,
    output logic             o_mem_req,
    output logic [31:0]      o_mem_addr,
    output logic             o_mem_unit_b,
    output logic             o_base_we,
    output logic             o_base_file_b,
    output logic [4:0]       o_base_idx,
    output logic [31:0]      o_base_wdata,
    output logic             o_dst_we,
    output logic             o_dst_file_b,
    output logic [4:0]       o_dst_idx,
    output logic [31:0]      o_dst_wdata
);

    // Elaboration checks on the widths the logic is built for.
    if (DW != 32)
    begin
        $error("DW must be 32");
    end

    // The pipe holds one stage less than the load delay, so it needs two slots.
    if (LOAD_DELAY_SLOTS < 2)
    begin
        $error("LOAD_DELAY_SLOTS must be at least two");
    end

    // -------------------------------------------------------------------------
    // Field extraction and decode.
    // -------------------------------------------------------------------------
    logic        long_form;
    logic        side_b;
    logic [2:0]  op;
    logic [3:0]  mode;
    logic [4:0]  base_idx;
    logic [4:0]  ofs_idx;
    logic [4:0]  dst_idx;
    logic        known_op;
    logic        is_load;
    logic [1:0]  shamt;

    // Returns the offset scaling for a load type.
    function automatic logic [1:0] scale_of(input logic [2:0] t);
        case (t)
            OP_SBYTE, OP_UBYTE : scale_of = 2'h0;
            OP_SHALF, OP_UHALF : scale_of = 2'h1;
            default            : scale_of = 2'h2;
        endcase
    endfunction

    // Tells whether a load type is served; the long form has no word load here.
    function automatic logic op_known(input logic [2:0] t, input logic lng);
        case (t)
            OP_SBYTE, OP_UBYTE : op_known = 1'b1;
            OP_SHALF, OP_UHALF : op_known = 1'b1;
            OP_WORD            : op_known = !lng;
            default            : op_known = 1'b0;
        endcase
    endfunction

    // Circular update of base within a block of 2^(n+1) bytes.
    function automatic logic [31:0] circ(input logic [31:0] b, input logic [31:0] r,
                                         input logic [4:0] n);
        logic [31:0] msk;
        msk  = (32'h0000_0002 << n) - 32'h0000_0001;
        circ = (b & ~msk) | (r & msk);
    endfunction

    // The long form is marked by both low format bits set.
    assign long_form = i_instr[FMT_BIT] & i_instr[FMT2_BIT];
    assign op        = i_instr[OP_LSB +: 3];
    assign mode      = i_instr[MODE_LSB +: 4];
    assign dst_idx   = i_instr[DST_LSB +: 5];
    assign ofs_idx   = i_instr[OFS_LSB +: 5];
    // Both load forms carry a one in the second format bit.
    assign is_load   = i_instr[FMT2_BIT];
    // Store types share the encoding space and are refused here.
    assign known_op  = op_known(op, long_form);
    // Offset scaling follows the access size.
    assign shamt     = scale_of(op);

    // Long form always runs on the second unit with B14 or B15.
    always_comb
    begin
        if (long_form)
        begin
            side_b   = 1'b1;
            base_idx = i_instr[Y_BIT] ? LONG_BASE_HI : LONG_BASE_LO;
        end
        else
        begin
            side_b   = i_instr[Y_BIT];
            base_idx = i_instr[BASE_LSB +: 5];
        end
    end

    // -------------------------------------------------------------------------
    // Register-file read ports for E1 operands.
    // -------------------------------------------------------------------------
    // Both sides see the same indices; only the executing side's data is used.
    assign o_a_rd_base_idx = base_idx;
    assign o_a_rd_ofs_idx  = ofs_idx;
    assign o_b_rd_base_idx = base_idx;
    assign o_b_rd_ofs_idx  = ofs_idx;

    // -------------------------------------------------------------------------
    // Address generation in E1.
    // -------------------------------------------------------------------------
    logic [31:0] base_val;
    logic [31:0] ofs_raw;
    logic [31:0] ofs_scaled;
    logic [31:0] calc;
    logic [31:0] linres;
    logic        sub;
    logic        post;
    logic        modify;
    logic        circ_en;
    logic [1:0]  circ_fld;
    logic [4:0]  blk;
    logic        fire;

    // Computes base, offset and the modified address for E1.
    always_comb
    begin
        base_val = side_b ? i_b_rd_base : i_a_rd_base;
        if (long_form)
        begin
            ofs_raw = {17'h00000, i_instr[LCST_LSB +: 15]};
        end
        else if (mode[2])
        begin
            ofs_raw = side_b ? i_b_rd_ofs : i_a_rd_ofs;
        end
        else
        begin
            ofs_raw = {27'h0000000, ofs_idx};
        end
        // Scales the offset by the access size.
        ofs_scaled = ofs_raw << shamt;
        // Bit 0 of the mode means add; long form never subtracts.
        sub    = long_form ? 1'b0 : !mode[0];
        post   = !long_form && mode[3] && mode[1];
        modify = !long_form && mode[3];
        // Linear sum or difference of base and scaled offset.
        linres = sub ? base_val - ofs_scaled : base_val + ofs_scaled;
        // Circular mode only for registers 4..7 of the short form.
        circ_fld = i_circ_mode[{side_b, base_idx[1:0], 1'b0} +: 2];
        // Field 10 takes block size B; 01 and 11 take block size A.
        blk      = (circ_fld == 2'h2) ? i_circ_blk_b : i_circ_blk_a;
        circ_en  = !long_form && (base_idx >= CIRC_REG_LO) && (base_idx <= CIRC_REG_HI)
                   && (circ_fld != 2'h0);
        calc     = circ_en ? circ(base_val, linres, blk) : linres;
    end

    // False predicate, unknown type or other format makes the slot a no-operation.
    assign fire = i_issue && i_pred_true && known_op && is_load;

    // Memory request leaves in E1; post modes address the unmodified base.
    assign o_mem_req     = fire;
    assign o_mem_addr    = post ? base_val : calc;
    assign o_mem_unit_b  = side_b;

    // Base write-back lands in E1 with no delay slot, on the executing side.
    assign o_base_we     = fire && modify;
    assign o_base_file_b = side_b;
    assign o_base_idx    = base_idx;
    assign o_base_wdata  = calc;

    // -------------------------------------------------------------------------
    // Destination write pipe to E5.
    // -------------------------------------------------------------------------
    bhl_wb_if wb_if ();
    logic        d_valid;
    logic        d_file_b;
    logic [4:0]  d_dst;
    logic [2:0]  d_op;
    logic [1:0]  d_lane;

    // Control word for the write that lands four slots later.
    assign wb_if.valid  = fire;
    assign wb_if.file_b = i_instr[S_BIT];
    assign wb_if.dst    = dst_idx;
    assign wb_if.op     = op;
    assign wb_if.lane   = o_mem_addr[1:0];

    bhl_delay_pipe #(
        .DEPTH (LOAD_DELAY_SLOTS - 1)
    ) u_pipe (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .in_if    (wb_if),
        .o_valid  (d_valid),
        .o_file_b (d_file_b),
        .o_dst    (d_dst),
        .o_op     (d_op),
        .o_lane   (d_lane)
    );

    // Picks and extends the loaded lane.
    function automatic logic [31:0] extend(input logic [2:0] t, input logic [1:0] ln,
                                           input logic [31:0] w);
        logic [7:0]  b;
        logic [15:0] h;
        b = w[{ln, 3'h0} +: 8];
        h = w[{ln[1], 4'h0} +: 16];
        case (t)
            OP_SBYTE : extend = {{24{b[7]}}, b};
            OP_UBYTE : extend = {24'h000000, b};
            OP_SHALF : extend = {{16{h[15]}}, h};
            OP_UHALF : extend = {16'h0000, h};
            default  : extend = w;
        endcase
    endfunction

    logic        we_reg;
    logic        we_next;
    logic        fb_reg;
    logic        fb_next;
    logic [4:0]  idx_reg;
    logic [4:0]  idx_next;
    logic [31:0] data_reg;
    logic [31:0] data_next;

    // Final stage captures memory data into the E5 write.
    always_comb
    begin
        we_next   = d_valid;
        fb_next   = d_file_b;
        idx_next  = d_dst;
        data_next = d_valid ? extend(d_op, d_lane, i_mem_rdata) : data_reg;
    end

    // Registers the destination write.
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            we_reg   <= 1'b0;
            fb_reg   <= 1'b0;
            idx_reg  <= 5'h00;
            data_reg <= RST_WORD;
        end
        else
        begin
            we_reg   <= we_next;
            fb_reg   <= fb_next;
            idx_reg  <= idx_next;
            data_reg <= data_next;
        end
    end

    assign o_dst_we     = we_reg;
    assign o_dst_file_b = fb_reg;
    assign o_dst_idx    = idx_reg;
    assign o_dst_wdata  = data_reg;

endmodule

// *** rtl/bhl_pkg.sv ***
package bhl_pkg;

    // -------------------------------------------------------------------------
    // Instruction field positions.
    // -------------------------------------------------------------------------
    localparam int DST_LSB      = 23;
    localparam int BASE_LSB     = 18;
    localparam int OFS_LSB      = 13;
    localparam int MODE_LSB     = 9;
    localparam int RSV_BIT      = 8;
    localparam int Y_BIT        = 7;
    localparam int OP_LSB       = 4;
    localparam int FMT_BIT      = 3;
    localparam int FMT2_BIT     = 2;
    localparam int S_BIT        = 1;
    localparam int LCST_LSB     = 8;

    // -------------------------------------------------------------------------
    // Load type field encodings.
    // -------------------------------------------------------------------------
    localparam logic [2:0] OP_SBYTE = 3'h2;
    localparam logic [2:0] OP_UBYTE = 3'h1;
    localparam logic [2:0] OP_SHALF = 3'h4;
    localparam logic [2:0] OP_UHALF = 3'h0;
    localparam logic [2:0] OP_WORD  = 3'h6;

    // -------------------------------------------------------------------------
    // Addressing mode field encodings.
    // -------------------------------------------------------------------------
    localparam logic [3:0] MD_NEG_CST  = 4'h0;
    localparam logic [3:0] MD_POS_CST  = 4'h1;
    localparam logic [3:0] MD_NEG_REG  = 4'h4;
    localparam logic [3:0] MD_POS_REG  = 4'h5;
    localparam logic [3:0] MD_PREDEC_C = 4'h8;
    localparam logic [3:0] MD_PREINC_C = 4'h9;
    localparam logic [3:0] MD_PSTDEC_C = 4'ha;
    localparam logic [3:0] MD_PSTINC_C = 4'hb;
    localparam logic [3:0] MD_PREDEC_R = 4'hc;
    localparam logic [3:0] MD_PREINC_R = 4'hd;
    localparam logic [3:0] MD_PSTDEC_R = 4'he;
    localparam logic [3:0] MD_PSTINC_R = 4'hf;

    // -------------------------------------------------------------------------
    // Pipeline timing and fixed bases.
    // -------------------------------------------------------------------------
    localparam int          LOAD_DELAY_SLOTS = 4;
    localparam logic [4:0]  LONG_BASE_LO     = 5'h0e;
    localparam logic [4:0]  LONG_BASE_HI     = 5'h0f;
    localparam logic [4:0]  CIRC_REG_LO      = 5'h04;
    localparam logic [4:0]  CIRC_REG_HI      = 5'h07;
    localparam logic [31:0] RST_WORD         = 32'h0000_0000;

endpackage

// *** rtl/bhl_wb_if.sv ***
`timescale 1ns/1ps
// Carries one load's control word into the delay pipe.
interface bhl_wb_if;
    logic        valid;
    logic        file_b;
    logic [4:0]  dst;
    logic [2:0]  op;
    logic [1:0]  lane;

    modport src (output valid, output file_b, output dst, output op, output lane);
    modport dly (input valid, input file_b, input dst, input op, input lane);
endinterface

// *** testbench/bhl_mem_model.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Data memory answering three clocks after a request.
// ---------------------------------------------------------------
module bhl_mem_model
(
    input  wire logic        i_clk,
    input  wire logic        i_req,
    input  wire logic [31:0] i_addr,
    output logic [31:0]      o_rdata
);
    logic [2:0]  vld_reg;
    logic [2:0]  vld_next;
    logic [31:0] adr_reg  [3];
    logic [31:0] adr_next [3];

    // Scrambled content, so every word and every lane differs.
    function automatic logic [31:0] word_at(input logic [31:0] a);
        return ({a[31:2], 2'b00} * 32'h9e37_79b1) ^ 32'h5a3c_96e1;
    endfunction

    // Moves each request down the access pipe.
    always_comb
    begin
        vld_next = {vld_reg[1:0], i_req};
        adr_next = '{i_addr, adr_reg[0], adr_reg[1]};
    end

    always_ff @(posedge i_clk)
    begin
        vld_reg <= vld_next;
        adr_reg <= adr_next;
    end

    // Data is good only in the sampling cycle; otherwise it is inverted.
    assign o_rdata = vld_reg[2] ? word_at(adr_reg[2]) : ~word_at(adr_reg[2]);
endmodule

// *** testbench/bhl_props.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Port checker for the load unit.
// ---------------------------------------------------------------
module bhl_props
    import bhl_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_resetn,
    input wire logic        i_issue,
    input wire logic [31:0] i_instr,
    input wire logic        i_pred_true,
    input wire logic [31:0] i_a_rd_base,
    input wire logic [31:0] i_b_rd_base,
    input wire logic        o_mem_req,
    input wire logic [31:0] o_mem_addr,
    input wire logic        o_mem_unit_b,
    input wire logic        o_base_we,
    input wire logic        o_base_file_b,
    input wire logic [4:0]  o_base_idx,
    input wire logic        o_dst_we,
    input wire logic        o_dst_file_b,
    input wire logic [4:0]  o_dst_idx,
    input wire logic [31:0] o_dst_wdata
);
    logic        lng;
    logic        byt;
    logic [2:0]  op;
    logic [31:0] ladr;
    logic [31:0] sbase;

    // Decodes the form and the expected long-form address.
    always_comb
    begin
        lng   = i_instr[FMT_BIT] & i_instr[FMT2_BIT];
        op    = i_instr[OP_LSB +: 3];
        byt   = (op == OP_SBYTE) || (op == OP_UBYTE);
        ladr  = i_b_rd_base + ({17'h0, i_instr[LCST_LSB +: 15]} << (byt ? 0 : 1));
        sbase = i_instr[Y_BIT] ? i_b_rd_base : i_a_rd_base;
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    sequence s_take(logic [2:0] t);
        o_mem_req && op == t;
    endsequence

    sequence s_wb;
        ##4 o_dst_we;
    endsequence

    AST_REQ_CAUSE: assert property (o_mem_req |-> i_issue && i_pred_true)
        else $error("memory request without a true issued instruction");
    AST_WB_CAUSE: assert property (o_base_we |-> o_mem_req && !lng)
        else $error("base write without a short-form access");
    AST_DST_TIME: assert property (o_mem_req |-> s_wb)
        else $error("destination write missing four cycles after access");
    AST_DST_ONLY: assert property (o_dst_we |-> $past(o_mem_req, 4))
        else $error("destination write without an access four cycles before");
    AST_UNIT: assert property (o_mem_req |-> o_mem_unit_b == (lng | i_instr[Y_BIT]))
        else $error("wrong data unit for the access");
    AST_LONG_ADDR: assert property (o_mem_req && lng |-> o_mem_addr == ladr)
        else $error("long-form address wrong");
    AST_POST_ADDR: assert property (o_mem_req && !lng && i_instr[MODE_LSB + 3] &&
        i_instr[MODE_LSB + 1] |-> o_mem_addr == sbase)
        else $error("post-modify access not at the original base");
    AST_WB_TARGET: assert property (o_base_we |-> o_base_idx == i_instr[BASE_LSB +: 5]
        && o_base_file_b == i_instr[Y_BIT])
        else $error("base write-back to the wrong register");
    AST_DST_FILE: assert property (o_mem_req |-> ##4 o_dst_file_b == $past(i_instr[S_BIT], 4)
        && o_dst_idx == $past(i_instr[DST_LSB +: 5], 4))
        else $error("destination file or index wrong");
    AST_UBYTE_ZERO: assert property (s_take(OP_UBYTE) |-> s_wb ##0 o_dst_wdata[31:8] == 24'h0)
        else $error("unsigned byte upper bits not cleared");
    AST_SHALF_SIGN: assert property (s_take(OP_SHALF) |-> s_wb ##0
        o_dst_wdata[31:16] == {16{o_dst_wdata[15]}})
        else $error("signed halfword upper bits not extended");
endmodule

bind bhl_load_unit bhl_props u_props (.i_clk, .i_resetn, .i_issue, .i_instr, .i_pred_true,
    .i_a_rd_base, .i_b_rd_base, .o_mem_req, .o_mem_addr, .o_mem_unit_b, .o_base_we,
    .o_base_file_b, .o_base_idx, .o_dst_we, .o_dst_file_b, .o_dst_idx, .o_dst_wdata);

// *** testbench/byte_halfword_load_unit_tb_top.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Self-checking bench for the load unit.
// ---------------------------------------------------------------
module byte_halfword_load_unit_tb_top
    import bhl_pkg::*;
;
    logic        i_clk       = 1'b0;
    logic        i_resetn    = 1'b0;
    logic        i_issue     = 1'b0;
    logic [31:0] i_instr     = 32'h0;
    logic        i_pred_true = 1'b0;
    logic [15:0] i_circ_mode  = 16'h0;
    logic [4:0]  i_circ_blk_a = 5'h0;
    logic [4:0]  i_circ_blk_b = 5'h0;
    logic [31:0] i_a_rd_base, i_a_rd_ofs, i_b_rd_base, i_b_rd_ofs, i_mem_rdata;
    logic [4:0]  o_a_rd_base_idx, o_a_rd_ofs_idx, o_b_rd_base_idx, o_b_rd_ofs_idx;
    logic        o_mem_req, o_mem_unit_b, o_base_we, o_base_file_b, o_dst_we, o_dst_file_b;
    logic [4:0]  o_base_idx, o_dst_idx;
    logic [31:0] o_mem_addr, o_base_wdata, o_dst_wdata;
    logic [31:0] reg_a [32];
    logic [31:0] reg_b [32];
    logic [37:0] exp_q [$];
    logic [3:0]  modes [12] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd,
                                4'he, 4'hf};
    logic [2:0]  ops   [6]  = '{OP_SBYTE, OP_UBYTE, OP_SHALF, OP_UHALF, OP_WORD, 3'h3};
    int          num_errors      = 0;
    int          samples_checked = 0;
    int          cycles          = 0;

    always #2 i_clk = ~i_clk;

    // Register files answer the unit's read indices.
    assign i_a_rd_base = reg_a[o_a_rd_base_idx];
    assign i_a_rd_ofs  = reg_a[o_a_rd_ofs_idx];
    assign i_b_rd_base = reg_b[o_b_rd_base_idx];
    assign i_b_rd_ofs  = reg_b[o_b_rd_ofs_idx];

    bhl_load_unit dut (.i_clk, .i_resetn, .i_issue, .i_instr, .i_pred_true, .i_a_rd_base,
        .i_a_rd_ofs, .i_b_rd_base, .i_b_rd_ofs, .i_circ_mode, .i_circ_blk_a, .i_circ_blk_b,
        .i_mem_rdata, .o_a_rd_base_idx, .o_a_rd_ofs_idx, .o_b_rd_base_idx, .o_b_rd_ofs_idx,
        .o_mem_req, .o_mem_addr, .o_mem_unit_b, .o_base_we, .o_base_file_b, .o_base_idx,
        .o_base_wdata, .o_dst_we, .o_dst_file_b, .o_dst_idx, .o_dst_wdata);

    bhl_mem_model u_mem (.i_clk(i_clk), .i_req(o_mem_req), .i_addr(o_mem_addr),
        .o_rdata(i_mem_rdata));

    task automatic chk(input string nm, input logic [37:0] exp, input logic [37:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic summarize();
        if (num_errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Works out the expected outcome, issues the instruction and checks the E1 side.
    task automatic run_op(input logic [31:0] ins, input logic pred);
        logic        lng;
        logic        y;
        logic        take;
        logic [2:0]  op;
        logic [3:0]  md;
        logic [1:0]  f;
        logic [31:0] base;
        logic [31:0] ofs;
        logic [31:0] calc;
        logic [31:0] addr;
        logic [31:0] w;
        logic [31:0] m;
        int          sh;
        lng  = ins[FMT_BIT] & ins[FMT2_BIT];
        y    = ins[Y_BIT];
        op   = ins[OP_LSB +: 3];
        md   = ins[MODE_LSB +: 4];
        sh   = (op == OP_SBYTE || op == OP_UBYTE) ? 0 : (op == OP_WORD) ? 2 : 1;
        take = pred && (op inside {OP_SBYTE, OP_UBYTE, OP_SHALF, OP_UHALF} ||
               (op == OP_WORD && !lng));
        base = lng ? reg_b[14 + y] : y ? reg_b[ins[BASE_LSB +: 5]] : reg_a[ins[BASE_LSB +: 5]];
        ofs  = lng ? {17'h0, ins[LCST_LSB +: 15]} : !md[2] ? {27'h0, ins[OFS_LSB +: 5]} :
               y ? reg_b[ins[OFS_LSB +: 5]] : reg_a[ins[OFS_LSB +: 5]];
        calc = (lng || md[0]) ? base + (ofs << sh) : base - (ofs << sh);
        f    = i_circ_mode[{y, ins[BASE_LSB +: 2], 1'b0} +: 2];
        m    = (32'h2 << ((f == 2'h2) ? i_circ_blk_b : i_circ_blk_a)) - 32'h1;
        if (!lng && ins[BASE_LSB + 2 +: 3] == 3'h1 && f != 2'h0)
            calc = (base & ~m) | (calc & m);
        addr = (!lng && md[3] && md[1]) ? base : calc;
        w    = u_mem.word_at(addr) >> ((op == OP_WORD) ? 0 : (sh == 0) ? addr[1:0] * 8 :
               addr[1] * 16);
        case (op)
            OP_SBYTE: w = {{24{w[7]}}, w[7:0]};
            OP_UBYTE: w = {24'h0, w[7:0]};
            OP_SHALF: w = {{16{w[15]}}, w[15:0]};
            OP_UHALF: w = {16'h0, w[15:0]};
            default:  w = w;
        endcase
        @(negedge i_clk);
        i_issue     = 1'b1;
        i_instr     = ins;
        i_pred_true = pred;
        #1;
        chk("mem_req", take, o_mem_req);
        chk("base_we", take && !lng && md[3], o_base_we);
        if (take)
        begin
            chk("mem_addr", addr, o_mem_addr);
            chk("mem_unit_b", lng | y, o_mem_unit_b);
            exp_q.push_back({ins[S_BIT], ins[DST_LSB +: 5], w});
        end
        if (o_base_we === 1'b1)
            chk("base_wb", {y, ins[BASE_LSB +: 5], calc}, {o_base_file_b, o_base_idx, o_base_wdata});
    endtask

    // Takes the oldest expected result whenever a destination write appears.
    always @(negedge i_clk)
    begin
        if (o_dst_we === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk("dst_we", 0, 1);
            else
                chk("dst", exp_q.pop_front(), {o_dst_file_b, o_dst_idx, o_dst_wdata});
        end
    end

    // Cuts a hang short.
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles > 2000)
        begin
            num_errors++;
            summarize();
        end
    end

    initial
    begin
        void'($urandom(32'hacb8));
        for (int i = 0; i < 32; i++)
        begin
            reg_a[i] = $urandom() & 32'hffff_fffc;
            reg_b[i] = $urandom() & 32'hffff_fffc;
        end
        i_circ_mode  = 16'($urandom());
        i_circ_blk_a = 5'($urandom() % 8);
        i_circ_blk_b = 5'($urandom() % 8);
        repeat (20) @(negedge i_clk);
        i_resetn = 1'b1;
        for (int k = 0; k < 216; k++)
            run_op({4'h0, 5'($urandom()), 2'h0, 3'($urandom()), 5'($urandom()), modes[k % 12],
                    1'b0, 1'($urandom()), ops[k / 12 % 6], 2'b01, 1'($urandom()), 1'b0},
                   ($urandom() % 8) != 0);
        for (int k = 0; k < 48; k++)
            run_op({4'h0, 5'($urandom()), 15'($urandom()), 1'($urandom()), ops[k % 6],
                    2'b11, 1'($urandom()), 1'b0}, 1'b1);
        @(negedge i_clk);
        i_issue = 1'b0;
        repeat (6) @(negedge i_clk);
        chk("queue_left", 0, exp_q.size());
        summarize();
    end
endmodule
